// >>> rtl/supply_control_supervisor.sv
// Supply control supervisor: rail decode, protection, address and queries
//
// Behaviour
// - Master-on low enables rails; hold low aux only
// - Debounce master-on and rail-hold inputs
// - Minimum interval between main rail enables
// - Debounce and lockout windows last 5 ms
// - Pins rule outputs while priority bit clear
// - Active-low slot pins give addresses 20h-23h
// - Slot address latched once at power-up
// - Slot pins debounced before latching
// - Both query ports share address and function
// - Fault mirrors hold at power-up, then faults
// - Hold line low until ready for control
// - Input outside window 1 ms: power-cycle
// - Monitored values sampled every 200 us
// - Overvoltage: fault, outputs off, retry 1 s
// - Overcurrent: fault, outputs off, retry 1 s
// - Shutdown at 95 C, resume 20 C lower
// - Clear warning bit 5 at 85 C
// - Query 21h hotter sensor, 92h both sensors
// - Honour temporary and permanent standalone selection
// - Bus address 01000 then slot bits
`timescale 1ns/100ps
`default_nettype none
`include "supply_ctrl_cfg.svh"

module supply_control_supervisor #(
  parameter int unsigned DEB_CYC    = `SCS_DEBOUNCE_US * `SCS_CLK_MHZ,
  parameter int unsigned SAMPLE_CYC = `SCS_SAMPLE_US * `SCS_CLK_MHZ,
  parameter int unsigned RETRY_CYC  = `SCS_RETRY_US * `SCS_CLK_MHZ,
  // One sample beyond the window so a trip always spans the full time
  parameter int unsigned INF_SAMP   =
    `SCS_INFAULT_US / `SCS_SAMPLE_US + 1
) (
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        master_on_n_in,
  input  wire logic        rail_hold_n_in,
  input  wire logic        slot_addr_bit0_n_in,
  input  wire logic        slot_addr_bit1_n_in,
  input  wire logic        input_window_ok_in,
  input  wire logic        output_overvoltage_in,
  input  wire logic        overcurrent_in,
  input  wire logic [15:0] temp_a_in,
  input  wire logic [15:0] temp_b_in,
  input  wire logic        sw_priority_in,
  input  wire logic        sw_main_en_in,
  input  wire logic        sw_aux_en_in,
  input  wire logic        warn_bit_set_in,
  input  wire logic        query_valid_in,
  input  wire logic        query_port_in,
  input  wire logic [7:0]  query_cmd_in,
  input  wire logic        mode_req_in,
  input  wire logic        mode_standalone_in,
  input  wire logic        stored_standalone_in,
  output logic             main_rails_out,
  output logic             aux_3v3_rail_out,
  output logic             system_hold_n_out,
  output logic             system_hold_n_oe_out,
  output logic             fault_n_out,
  output logic             fault_n_oe_out,
  output logic [6:0]       i2c_addr_out,
  output logic             comm_enable_out,
  output logic             warn_bit_out,
  output logic             resp_valid_out,
  output logic             resp_port_out,
  output logic             resp_error_out,
  output logic [31:0]      resp_data_out,
  output logic             standalone_out,
  output logic             store_write_out,
  output logic             store_value_out,
  output logic             sample_tick_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Debounce of control and slot pins

  logic [3:0]  raw;
  logic [3:0]  db_q;
  logic [31:0] db_cnt_q [4];
  logic [31:0] up_cnt_q;
  logic        addr_ready;

  assign raw = {slot_addr_bit1_n_in, slot_addr_bit0_n_in,
                rail_hold_n_in, master_on_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_deb
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          db_q[gi]     <= 1'b1;
          db_cnt_q[gi] <= 32'h0;
        end else if (raw[gi] == db_q[gi]) begin
          db_cnt_q[gi] <= 32'h0;
        end else if (db_cnt_q[gi] >= DEB_CYC - 1) begin
          db_q[gi]     <= raw[gi];
          db_cnt_q[gi] <= 32'h0;
        end else begin
          db_cnt_q[gi] <= db_cnt_q[gi] + 32'h1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sample divider and input window qualification

  logic [31:0] samp_cnt_q;
  logic [7:0]  inf_cnt_q;
  logic        in_fault_q;
  logic        tick;

  assign tick = (samp_cnt_q == SAMPLE_CYC - 1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      samp_cnt_q      <= 32'h0;
      sample_tick_out <= 1'b0;
    end else begin
      samp_cnt_q      <= tick ? 32'h0 : samp_cnt_q + 32'h1;
      sample_tick_out <= tick;
    end
  end

  // Needs the bad level on consecutive samples; one good sample restarts it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inf_cnt_q  <= 8'h0;
      in_fault_q <= 1'b0;
    end else if (tick) begin
      if (input_window_ok_in) begin
        inf_cnt_q  <= 8'h0;
        in_fault_q <= 1'b0;
      end else if (inf_cnt_q >= INF_SAMP[7:0] - 8'h1) begin
        in_fault_q <= 1'b1;
      end else begin
        inf_cnt_q <= inf_cnt_q + 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection state machine

  supply_ctrl_pkg::sup_state_t state_q;
  logic [31:0] retry_cnt_q;
  logic [15:0] hot_q;
  logic        ov_q;
  logic        oc_q;

  // Hotter-sensor value and fault inputs are taken only on the sample tick
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hot_q <= 16'h0;
      ov_q  <= 1'b0;
      oc_q  <= 1'b0;
    end else if (tick) begin
      hot_q <= (temp_a_in > temp_b_in) ? temp_a_in : temp_b_in;
      ov_q  <= output_overvoltage_in;
      oc_q  <= overcurrent_in;
    end
  end

  assign addr_ready = (up_cnt_q >= DEB_CYC);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      up_cnt_q <= 32'h0;
    end else if (state_q == supply_ctrl_pkg::ST_POWERUP && !in_fault_q) begin
      if (!addr_ready) begin
        up_cnt_q <= up_cnt_q + 32'h1;
      end
    end else if (state_q == supply_ctrl_pkg::ST_POWERUP) begin
      up_cnt_q <= 32'h0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q     <= supply_ctrl_pkg::ST_POWERUP;
      retry_cnt_q <= 32'h0;
    end else if (in_fault_q) begin
      state_q <= supply_ctrl_pkg::ST_POWERUP;
    end else begin
      unique case (state_q)
        supply_ctrl_pkg::ST_POWERUP: begin
          if (addr_ready) begin
            state_q <= supply_ctrl_pkg::ST_RUN;
          end
        end
        supply_ctrl_pkg::ST_RUN: begin
          if (hot_q >= `SCS_TEMP_SHUT) begin
            state_q <= supply_ctrl_pkg::ST_HOT;
          end else if (ov_q || oc_q) begin
            state_q     <= supply_ctrl_pkg::ST_RETRY;
            retry_cnt_q <= 32'h0;
          end
        end
        supply_ctrl_pkg::ST_RETRY: begin
          if (retry_cnt_q >= RETRY_CYC - 1) begin
            retry_cnt_q <= 32'h0;
            if (!ov_q && !oc_q) begin
              state_q <= supply_ctrl_pkg::ST_RUN;
            end
          end else begin
            retry_cnt_q <= retry_cnt_q + 32'h1;
          end
        end
        supply_ctrl_pkg::ST_HOT: begin
          if (hot_q <= `SCS_TEMP_SHUT - `SCS_TEMP_DROP) begin
            state_q <= supply_ctrl_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail decode with lockout

  logic        want_main;
  logic        want_aux;
  logic        run;
  logic [31:0] lock_cnt_q;

  assign run = (state_q == supply_ctrl_pkg::ST_RUN);

  always_comb begin
    if (sw_priority_in) begin
      want_main = sw_main_en_in;
      want_aux  = sw_aux_en_in;
    end else begin
      want_main = !db_q[0] && db_q[1];
      want_aux  = !db_q[0];
    end
  end

  // Lockout spaces restarts so a large load capacitance is not hammered
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_rails_out   <= 1'b0;
      aux_3v3_rail_out <= 1'b0;
      lock_cnt_q       <= 32'h0;
    end else begin
      aux_3v3_rail_out <= run && want_aux;
      if (!(run && want_main)) begin
        main_rails_out <= 1'b0;
      end else if (!main_rails_out && lock_cnt_q == 32'h0) begin
        main_rails_out <= 1'b1;
      end
      // Runs down in every state, so a pending re-enable cannot stall
      if (lock_cnt_q != 32'h0) begin
        lock_cnt_q <= lock_cnt_q - 32'h1;
      end
      if (run && want_main && !main_rails_out && lock_cnt_q == 32'h0) begin
        lock_cnt_q <= DEB_CYC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain status lines, address, warning bit

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      system_hold_n_out    <= 1'b0;
      system_hold_n_oe_out <= 1'b1;
      fault_n_out          <= 1'b0;
      fault_n_oe_out       <= 1'b1;
      comm_enable_out      <= 1'b0;
    end else begin
      system_hold_n_oe_out <= (state_q == supply_ctrl_pkg::ST_POWERUP);
      fault_n_oe_out       <= (state_q != supply_ctrl_pkg::ST_RUN);
      comm_enable_out      <= (state_q != supply_ctrl_pkg::ST_POWERUP);
    end
  end

  // Caught at the power-up release, never again until the next power cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      i2c_addr_out <= {`SCS_ADDR_BASE, 2'h0};
    end else if (state_q == supply_ctrl_pkg::ST_POWERUP && addr_ready) begin
      i2c_addr_out <= {`SCS_ADDR_BASE, !db_q[3], !db_q[2]};
    end
  end

  // Hardware clear beats a manager set in the same cycle
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warn_bit_out <= 1'b0;
    end else if (hot_q >= `SCS_TEMP_WARN) begin
      warn_bit_out <= 1'b0;
    end else if (warn_bit_set_in) begin
      warn_bit_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperature queries, either port

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resp_valid_out <= 1'b0;
      resp_port_out  <= 1'b0;
      resp_error_out <= 1'b0;
      resp_data_out  <= 32'h0;
    end else begin
      resp_valid_out <= query_valid_in && comm_enable_out;
      if (query_valid_in && comm_enable_out) begin
        resp_port_out  <= query_port_in;
        resp_error_out <= 1'b0;
        if (query_cmd_in == `SCS_CMD_HOT) begin
          resp_data_out <= {16'h0, hot_q};
        end else if (query_cmd_in == `SCS_CMD_BOTH) begin
          resp_data_out <= {temp_a_in, temp_b_in};
        end else begin
          resp_data_out  <= 32'h0;
          resp_error_out <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Standalone / paralleling selection

  logic [1:0] same_cnt_q;
  logic       last_sel_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      standalone_out  <= 1'b0;
      store_write_out <= 1'b0;
      store_value_out <= 1'b0;
      same_cnt_q      <= 2'h0;
      last_sel_q      <= 1'b0;
    end else begin
      store_write_out <= 1'b0;
      if (state_q == supply_ctrl_pkg::ST_POWERUP) begin
        standalone_out <= stored_standalone_in;
        same_cnt_q     <= 2'h0;
      end else if (mode_req_in && comm_enable_out) begin
        standalone_out <= mode_standalone_in;
        last_sel_q     <= mode_standalone_in;
        if (same_cnt_q != 2'h0 && last_sel_q != mode_standalone_in) begin
          same_cnt_q <= 2'h1;
        end else if (same_cnt_q == `SCS_COMMIT_COUNT - 2'h1) begin
          same_cnt_q      <= 2'h0;
          store_write_out <= 1'b1;
          store_value_out <= mode_standalone_in;
        end else begin
          same_cnt_q <= same_cnt_q + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_master_off: assert property (
    db_q[0] && !sw_priority_in |=> !main_rails_out && !aux_3v3_rail_out)
    else $error("rails on while master-on released");
  a_aux_only: assert property (
    run && !sw_priority_in && !db_q[0] && !db_q[1]
    |=> !main_rails_out && aux_3v3_rail_out)
    else $error("main rails on with rail-hold low");
  a_glitch_filter: assert property (
    $changed(db_q[0]) |-> $past(raw[0], 2) == db_q[0])
    else $error("debounced level not held by pin");
  a_lockout_gap: assert property (
    $rose(main_rails_out) |-> lock_cnt_q == DEB_CYC)
    else $error("enable without lockout load");
  a_hold_low: assert property (
    state_q == supply_ctrl_pkg::ST_POWERUP |=> system_hold_n_oe_out)
    else $error("hold released during power-up");
  a_fault_ovp: assert property (
    run && ov_q && hot_q < `SCS_TEMP_SHUT && !in_fault_q
    |=> ##1 fault_n_oe_out)
    else $error("fault not driven on overvoltage");
  a_addr_fixed: assert property (
    state_q != supply_ctrl_pkg::ST_POWERUP |=> $stable(i2c_addr_out))
    else $error("address changed after power-up");
  a_hot_off: assert property (
    state_q == supply_ctrl_pkg::ST_HOT
    |=> !main_rails_out && !aux_3v3_rail_out)
    else $error("rails on during overtemperature");
  a_warn_clear: assert property (
    hot_q >= `SCS_TEMP_WARN |=> !warn_bit_out)
    else $error("warning bit not cleared");
  a_query_answer: assert property (
    query_valid_in && comm_enable_out && query_cmd_in == `SCS_CMD_HOT
    |=> resp_valid_out && resp_data_out[15:0] == $past(hot_q))
    else $error("hot query answer wrong");

  c_fault_retry: cover property (state_q == supply_ctrl_pkg::ST_RETRY ##1 run);
  c_hot_recover: cover property (state_q == supply_ctrl_pkg::ST_HOT ##1 run);
  c_store_write: cover property (store_write_out);
  c_main_on: cover property ($rose(main_rails_out));

endmodule
`default_nettype wire

// >>> rtl/supply_ctrl_cfg.svh
// Timing figures, thresholds and address constants of the supply controller
`ifndef SUPPLY_CTRL_CFG_SVH
`define SUPPLY_CTRL_CFG_SVH

`define SCS_CLK_MHZ        100
`define SCS_DEBOUNCE_US    5000
`define SCS_INFAULT_US     1000
`define SCS_SAMPLE_US      200
`define SCS_RETRY_US       1000000

`define SCS_ADDR_BASE      5'h08
`define SCS_TEMP_SHUT      16'h03b6
`define SCS_TEMP_DROP      16'h00c8
`define SCS_TEMP_WARN      16'h0352

`define SCS_CMD_HOT        8'h21
`define SCS_CMD_BOTH       8'h92
`define SCS_COMMIT_COUNT   2'h3

`endif

// >>> rtl/supply_ctrl_pkg.sv
// Types shared by the supply controller
`default_nettype none
package supply_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_RUN     = 2'b01,
    ST_RETRY   = 2'b10,
    ST_HOT     = 2'b11
  } sup_state_t;
endpackage
`default_nettype wire

// >>> test/backplane_manager_model.sv
// Backplane manager side: pull-ups on the shared open-drain lines
`timescale 1ns/100ps
`default_nettype none

module backplane_manager_model (
  input  wire logic hold_drv_in,
  input  wire logic hold_oe_in,
  input  wire logic fault_drv_in,
  input  wire logic fault_oe_in,
  output logic      hold_line_out,
  output logic      fault_line_out
);
  // A released line floats up to the pull-up, never to the last value
  assign hold_line_out  = hold_oe_in ? hold_drv_in : 1'b1;
  assign fault_line_out = fault_oe_in ? fault_drv_in : 1'b1;
endmodule

`default_nettype wire

// >>> test/supply_control_supervisor_tb_top.sv
// Self-checking bench for the supply control supervisor
`timescale 1ns/100ps
`default_nettype none

module supply_control_supervisor_tb_top;
  // Short counts keep the run small; every debounce, sample and retry wait below derives from them
  localparam int DEB = 20;
  localparam int SMP = 4;
  localparam int RTY = 50;
  logic        sys_clk_in = 1'b0;
  logic        rst_n      = 1'b0;
  logic        on_n       = 1'b1;
  logic        hold_n     = 1'b1;
  logic        ga0_n      = 1'b0;
  logic        ga1_n      = 1'b1;
  logic        win_ok     = 1'b1;
  logic        ov         = 1'b0;
  logic        oc         = 1'b0;
  logic [15:0] temp_a     = 16'h0100;
  logic [15:0] temp_b     = 16'h0200;
  logic        pri        = 1'b0;
  logic        sw_main    = 1'b0;
  logic        sw_aux     = 1'b0;
  logic        warn_set   = 1'b0;
  logic        q_valid    = 1'b0;
  logic        q_port     = 1'b0;
  logic [7:0]  q_cmd      = 8'h00;
  logic        mode_req   = 1'b0;
  logic        mode_sa    = 1'b0;
  logic        stored_sa  = 1'b0;
  wire logic        main, aux, hold_drv, hold_oe, fault_drv, fault_oe;
  wire logic        comm, warn, rv, rport, rerr, sa, st_wr, st_val, tick;
  wire logic        hold_line, fault_line;
  wire logic [6:0]  addr;
  wire logic [31:0] rdata;
  wire logic [7:0]  st;
  int n_errors  = 0;
  int tests_run = 0;
  int wr_cnt    = 0;
  int tick_cnt  = 0;
  int k;
  int c0;
  logic [1:0] pin_tab [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
  logic [1:0] out_tab [4] = '{2'b11, 2'b01, 2'b00, 2'b00};

  assign st = {comm, main, aux, hold_line, fault_line, warn, sa, rv};

  ////////////////////////////////////////////////////////////////////////////
  supply_control_supervisor #(.DEB_CYC(DEB), .SAMPLE_CYC(SMP),
    .RETRY_CYC(RTY), .INF_SAMP(5)) dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(rst_n),
    .master_on_n_in(on_n), .rail_hold_n_in(hold_n),
    .slot_addr_bit0_n_in(ga0_n), .slot_addr_bit1_n_in(ga1_n),
    .input_window_ok_in(win_ok), .output_overvoltage_in(ov),
    .overcurrent_in(oc), .temp_a_in(temp_a), .temp_b_in(temp_b),
    .sw_priority_in(pri), .sw_main_en_in(sw_main), .sw_aux_en_in(sw_aux),
    .warn_bit_set_in(warn_set), .query_valid_in(q_valid),
    .query_port_in(q_port), .query_cmd_in(q_cmd), .mode_req_in(mode_req),
    .mode_standalone_in(mode_sa), .stored_standalone_in(stored_sa),
    .main_rails_out(main), .aux_3v3_rail_out(aux),
    .system_hold_n_out(hold_drv), .system_hold_n_oe_out(hold_oe),
    .fault_n_out(fault_drv), .fault_n_oe_out(fault_oe),
    .i2c_addr_out(addr), .comm_enable_out(comm), .warn_bit_out(warn),
    .resp_valid_out(rv), .resp_port_out(rport), .resp_error_out(rerr),
    .resp_data_out(rdata), .standalone_out(sa), .store_write_out(st_wr),
    .store_value_out(st_val), .sample_tick_out(tick));

  backplane_manager_model mgr (
    .hold_drv_in(hold_drv), .hold_oe_in(hold_oe),
    .fault_drv_in(fault_drv), .fault_oe_in(fault_oe),
    .hold_line_out(hold_line), .fault_line_out(fault_line));

  always #5 sys_clk_in = ~sys_clk_in;

  always @(posedge sys_clk_in) begin
    if (st_wr === 1'b1) wr_cnt++;
    if (tick === 1'b1) tick_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Bounded wait on one status bit; running out ends the run
  task automatic wait_st(input int b, input logic v, input int lim,
                         input string nm);
    for (int i = 0; i < lim && st[b] !== v; i++) begin
      @(posedge sys_clk_in);
      #1;
    end
    chk(nm, 32'(v), 32'(st[b]));
    if (st[b] !== v) final_report();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic query(input logic p, input logic [7:0] c,
                       input logic [31:0] e, input logic er);
    @(posedge sys_clk_in);
    q_valid <= 1'b1;
    q_port <= p;
    q_cmd <= c;
    @(posedge sys_clk_in);
    q_valid <= 1'b0;
    #1;
    wait_st(0, 1'b1, 3, "resp_valid");
    chk("resp_port", 32'(p), 32'(rport));
    chk("resp_error", 32'(er), 32'(rerr));
    if (!er) chk("resp_data", e, rdata);
  endtask

  task automatic mode(input logic s);
    @(posedge sys_clk_in);
    mode_req <= 1'b1;
    mode_sa <= s;
    @(posedge sys_clk_in);
    mode_req <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    n_errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    chk("reset_lines", 32'h0, 32'({comm, main, aux, hold_line, fault_line}));
    @(posedge sys_clk_in);
    rst_n <= 1'b1;
    ga1_n <= 1'b0;
    cyc(3);
    @(posedge sys_clk_in);
    ga1_n <= 1'b1;
    cyc(2);
    chk("fault_mirror", 32'(hold_line), 32'(fault_line));
    wait_st(4, 1'b1, DEB + 10, "hold_release");
    chk("run_lines", 32'h3, 32'({comm, fault_line}));
    chk("slot_addr", 32'h21, 32'(addr));
    @(posedge sys_clk_in);
    ga1_n <= 1'b0;
    ga0_n <= 1'b1;
    #1;
    c0 = tick_cnt;
    cyc(10 * SMP);
    chk("tick_count", 32'd10, 32'(tick_cnt - c0));
    chk("addr_fixed", 32'h21, 32'(addr));
    @(posedge sys_clk_in);
    on_n <= 1'b0;
    cyc(3);
    @(posedge sys_clk_in);
    on_n <= 1'b1;
    cyc(2 * DEB);
    chk("glitch", 32'h0, 32'({main, aux}));
    @(posedge sys_clk_in);
    on_n <= 1'b0;
    cyc(DEB - 4);
    chk("deb_window", 32'h0, 32'({main, aux}));
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk_in);
      on_n <= pin_tab[k][1];
      hold_n <= pin_tab[k][0];
      wait_st(6, out_tab[k][1], 3 * DEB + 10, "main_rail");
      cyc(2 * DEB);
      chk("rails", 32'(out_tab[k]), 32'({main, aux}));
    end
    @(posedge sys_clk_in);
    on_n <= 1'b0;
    wait_st(6, 1'b1, 3 * DEB + 10, "main_on");
    @(posedge sys_clk_in);
    pri <= 1'b1;
    sw_aux <= 1'b1;
    wait_st(6, 1'b0, 3 * DEB + 10, "sw_main_off");
    chk("sw_aux", 32'h1, 32'(aux));
    @(posedge sys_clk_in);
    pri <= 1'b0;
    wait_st(6, 1'b1, 3 * DEB + 10, "pins_rule");
    query(1'b0, 8'h21, 32'h0000_0200, 1'b0);
    query(1'b1, 8'h92, 32'h0100_0200, 1'b0);
    query(1'b0, 8'h00, 32'h0, 1'b1);
    @(posedge sys_clk_in);
    warn_set <= 1'b1;
    @(posedge sys_clk_in);
    warn_set <= 1'b0;
    temp_a <= 16'h0351;
    cyc(4 * SMP);
    chk("warn_kept", 32'h1, 32'(warn));
    @(posedge sys_clk_in);
    temp_a <= 16'h0352;
    wait_st(2, 1'b0, 3 * SMP, "warn_clear");
    query(1'b1, 8'h21, 32'h0000_0352, 1'b0);
    @(posedge sys_clk_in);
    temp_a <= 16'h03b5;
    cyc(3 * SMP);
    chk("below_shut", 32'h1, 32'(main));
    @(posedge sys_clk_in);
    temp_a <= 16'h03b6;
    wait_st(6, 1'b0, 3 * SMP, "hot_off");
    chk("hot_fault", 32'h0, 32'(fault_line));
    @(posedge sys_clk_in);
    temp_a <= 16'h02ef;
    cyc(3 * SMP);
    chk("hot_hold", 32'h0, 32'(main));
    @(posedge sys_clk_in);
    temp_a <= 16'h02ee;
    wait_st(6, 1'b1, 3 * SMP + 3 * DEB, "hot_resume");
    for (k = 0; k < 2; k++) begin
      @(posedge sys_clk_in);
      ov <= (k == 0);
      oc <= (k == 1);
      wait_st(6, 1'b0, 3 * SMP, "prot_off");
      chk("prot_fault", 32'h0, 32'(fault_line));
      cyc(RTY + 2 * SMP);
      chk("retry_held", 32'h0, 32'(main));
      @(posedge sys_clk_in);
      ov <= 1'b0;
      oc <= 1'b0;
      wait_st(6, 1'b1, RTY + 3 * SMP + 3 * DEB, "retry_on");
      chk("fault_gone", 32'h1, 32'(fault_line));
    end
    @(posedge sys_clk_in);
    win_ok <= 1'b0;
    cyc(3 * SMP);
    chk("win_short", 32'h1, 32'(comm));
    wait_st(7, 1'b0, 4 * SMP, "comm_off");
    chk("win_lines", 32'h0, 32'({main, hold_line}));
    @(posedge sys_clk_in);
    win_ok <= 1'b1;
    wait_st(4, 1'b1, DEB + 6 * SMP, "win_back");
    chk("relatch", 32'h22, 32'(addr));
    mode(1'b1);
    chk("temp_mode", 32'h1, 32'(sa));
    mode(1'b1);
    mode(1'b1);
    cyc(2);
    chk("store_cnt", 32'd1, 32'(wr_cnt));
    chk("store_val", 32'h1, 32'(st_val));
    mode(1'b0);
    chk("back_share", 32'h0, 32'(sa));
    for (k = 0; k < 4; k++) begin
      @(posedge sys_clk_in);
      rst_n <= 1'b0;
      ga1_n <= ~k[1];
      ga0_n <= ~k[0];
      stored_sa <= k[0];
      cyc(2);
      @(posedge sys_clk_in);
      rst_n <= 1'b1;
      wait_st(4, 1'b1, DEB + 10, "hold_release");
      chk("slot_addr", 32'h20 + 32'(k), 32'(addr));
      chk("stored_mode", 32'(k[0]), 32'(sa));
    end
    final_report();
  end
endmodule

`default_nettype wire
